// *** rtl/exu_core.sv ***
// exception context save and restore unit with apb register access
//
// Behaviour
// - exception saves machine state and resume address
// - resume is faulting or next instruction address
// - take only when older instructions completed
// - return copies saved status into machine state
// - upper half info, machine bits 16-31 copied
// - most exceptions clear 0-5,7-15, copy bit 6
// - vector-available low blocks vector instructions
// - streaming instructions ignore vector-available bit
// - vector-available high allows all vector instructions
// - save-mask register never gated by vector bit
// - bit 13 selects reduced power mode
// - exception copies little-endian select into mode
//
// Register access over APB and the placing of the registers were left to the implementer.
`timescale 1ns/100ps
`include "exu_cfg.svh"
module exu_core #(
  parameter int ADDR_W = 8  // apb address width
) (
  // clock, reset and clock enable
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  input  wire logic                   ce,
  // apb slave
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [ADDR_W-1:0]      paddr,
  input  wire exu_pkg::exu_word_t     pwdata,
  output      exu_pkg::exu_word_t     prdata,
  output      logic                   pready,
  output      logic                   pslverr,
  // exception request from completion logic
  input  wire logic                   exc_req,
  input  wire logic                   exc_older_done,
  input  wire logic                   exc_use_next,
  input  wire logic                   exc_specific,
  input  wire exu_pkg::exu_info_t     exc_info,
  input  wire exu_pkg::exu_word_t     exc_pc,
  input  wire exu_pkg::exu_word_t     exc_next_pc,
  output      logic                   exc_ack,
  output      logic                   dispatch_hold,
  // return from exception
  input  wire logic                   rfi_req,
  output      logic                   rfi_ack,
  output      exu_pkg::exu_word_t     resume_addr,
  // vector dispatch check
  input  wire logic                   vreq_valid,
  input  wire logic                   vreq_stream,
  input  wire logic                   vreq_vsave,
  output      logic                   vreq_grant,
  output      logic                   vreq_unavail,
  // mode outputs
  output      logic                   vector_available,
  output      logic                   power_mgmt_mode,
  output      logic                   little_endian_mode,
  // interrupt
  output      logic                   irq
);
  import exu_pkg::*;

  // ***********************************************
  // elaboration check
  // ***********************************************
  if (ADDR_W < `EXU_ADDR_MIN_W) begin : g_addr_chk
    $error("exu_core: ADDR_W must be at least 8");
  end

  exu_state_t st_ff;   // all registered state
  exu_state_t nxt_st;  // next state
  exu_vec_if  vif ();  // link to the vector gate

  logic       take;       // exception accepted this cycle
  logic       ret;        // return accepted this cycle
  logic       setup;      // apb setup cycle
  logic       wr_en;      // apb write completes
  logic       hit;        // address is mapped
  logic [7:0] ofs;        // low address byte
  logic       upper_ok;   // address bits above byte are zero
  exu_word_t  rd_val;     // read mux result
  logic [`EXU_IRQ_W-1:0] irq_set;  // events this cycle

  // ***********************************************
  // vector gate
  // ***********************************************
  assign vif.vreq_valid  = vreq_valid;
  assign vif.vreq_stream = vreq_stream;
  assign vif.vreq_vsave  = vreq_vsave;
  assign vif.vec_avail   = st_ff.mstate[`EXU_MS_VEC];

  exu_vec_gate u_gate (
    .pclk    (pclk),
    .presetn (presetn),
    .ce      (ce),
    .vif     (vif.gate)
  );

  // ***********************************************
  // request qualification
  // ***********************************************
  // an exception waits until every older instruction has completed;
  // the ack cycle is masked so a request still high is not taken twice
  assign take = exc_req && exc_older_done && !st_ff.exc_ack;
  // an exception in the same cycle wins over a return
  assign ret  = rfi_req && !take && !st_ff.rfi_ack;

  // apb decode
  assign setup    = psel && !penable;
  assign wr_en    = psel && penable && st_ff.pready && pwrite;
  assign ofs      = paddr[7:0];
  assign upper_ok = (paddr >> 8) == '0;

  // ***********************************************
  // read mux and address decode
  // ***********************************************
  always_comb begin
    rd_val = '0;
    hit    = upper_ok;
    case (ofs)
      `EXU_OFS_RESUME:  rd_val = st_ff.resume;
      `EXU_OFS_SAVED:   rd_val = st_ff.saved;
      // reserved machine-state bits are held at zero
      `EXU_OFS_MSTATE:  rd_val = st_ff.mstate;
      `EXU_OFS_IRQ_STS: rd_val = {29'h0, st_ff.irq_sts};
      `EXU_OFS_IRQ_MSK: rd_val = {29'h0, st_ff.irq_msk};
      default:          hit    = 1'b0;  // unmapped: error answer
    endcase
  end

  // ***********************************************
  // next-state logic
  // ***********************************************
  always_comb begin
    nxt_st = st_ff;
    irq_set = '0;

    // apb answers one cycle after setup, zero wait in access
    nxt_st.pready  = setup;
    nxt_st.pslverr = setup && !hit;
    if (setup) begin
      nxt_st.prdata = hit ? rd_val : '0;
    end

    // software writes; hardware events below override them
    if (wr_en && hit) begin
      case (ofs)
        `EXU_OFS_RESUME:  nxt_st.resume = pwdata;
        `EXU_OFS_SAVED:   nxt_st.saved  = pwdata;
        `EXU_OFS_MSTATE:
          nxt_st.mstate = pwdata & `EXU_MS_IMPL_MASK;
        `EXU_OFS_IRQ_STS:
          nxt_st.irq_sts = st_ff.irq_sts & ~pwdata[`EXU_IRQ_W-1:0];
        `EXU_OFS_IRQ_MSK:
          nxt_st.irq_msk = pwdata[`EXU_IRQ_W-1:0];
        default: ;
      endcase
    end

    // exception: save context before the handler runs
    nxt_st.exc_ack = take;
    if (take) begin
      // system call and trace ask for the next address
      nxt_st.resume = exc_use_next ? exc_next_pc : exc_pc;
      // low half always copies machine-state bits 16..31
      nxt_st.saved[`EXU_SV_COPY_HI:0] =
        st_ff.mstate[`EXU_SV_COPY_HI:0];
      if (exc_specific) begin
        nxt_st.saved[`EXU_SV_INFO_HI:`EXU_SV_INFO_LO] = exc_info;
      end else begin
        // common form keeps only the vector-available bit
        nxt_st.saved[`EXU_SV_INFO_HI:`EXU_SV_INFO_LO] = '0;
        nxt_st.saved[`EXU_MS_VEC] = st_ff.mstate[`EXU_MS_VEC];
      end
      // handler runs in the byte order chosen beforehand
      nxt_st.mstate[`EXU_MS_LE] = st_ff.mstate[`EXU_MS_ILE];
      irq_set[`EXU_IRQ_TAKE] = 1'b1;
    end

    // return: restore machine state from the saved copy
    nxt_st.rfi_ack = ret;
    if (ret) begin
      nxt_st.mstate = st_ff.saved & `EXU_MS_IMPL_MASK;
      irq_set[`EXU_IRQ_RFI] = 1'b1;
    end

    // dispatch stays held while an exception waits
    nxt_st.hold = exc_req && !take;

    irq_set[`EXU_IRQ_VUN] = vif.unavail;
    // a set in the clearing cycle survives
    nxt_st.irq_sts = nxt_st.irq_sts | irq_set;
    nxt_st.irq     = |(nxt_st.irq_sts & nxt_st.irq_msk);

    // mode copies driven straight from flops
    nxt_st.vec = nxt_st.mstate[`EXU_MS_VEC];
    // power effect itself is left to the clock controller
    nxt_st.power_mgmt_enable = nxt_st.mstate[`EXU_MS_POW];
    nxt_st.le  = nxt_st.mstate[`EXU_MS_LE];
  end

  // ***********************************************
  // state register
  // ***********************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff         <= '0;
      st_ff.resume  <= `EXU_WORD_RESET;
      st_ff.saved   <= `EXU_WORD_RESET;
      st_ff.mstate  <= `EXU_MS_RESET;
      st_ff.irq_sts <= `EXU_IRQ_RESET;
      st_ff.irq_msk <= `EXU_IRQ_RESET;
    end else if (ce) begin
      st_ff <= nxt_st;
    end
  end

  // ***********************************************
  // outputs
  // ***********************************************
  assign prdata             = st_ff.prdata;
  assign pready             = st_ff.pready;
  assign pslverr            = st_ff.pslverr;
  assign exc_ack            = st_ff.exc_ack;
  assign dispatch_hold      = st_ff.hold;
  assign rfi_ack            = st_ff.rfi_ack;
  assign resume_addr        = st_ff.resume;
  assign vreq_grant         = vif.grant;
  assign vreq_unavail       = vif.unavail;
  assign vector_available   = st_ff.vec;
  assign power_mgmt_mode    = st_ff.power_mgmt_enable;
  assign little_endian_mode = st_ff.le;
  assign irq                = st_ff.irq;

  // ***********************************************
  // checks
  // ***********************************************
  AST_TAKE_RESUME: assert property (@(posedge pclk) disable iff (!presetn)
    ce && take |=> st_ff.resume ==
      ($past(exc_use_next) ? $past(exc_next_pc) : $past(exc_pc)))
    else $error("resume address not saved from the right source");

  AST_TAKE_ACK: assert property (@(posedge pclk) disable iff (!presetn)
    ce && take |=> exc_ack && st_ff.saved[15:0] == $past(st_ff.mstate[15:0]))
    else $error("context not saved when exception acknowledged");

  AST_SAVED_INFO: assert property (@(posedge pclk) disable iff (!presetn)
    ce && take && exc_specific |=> st_ff.saved[31:16] == $past(exc_info))
    else $error("exception info missing from saved status");

  AST_SAVED_COMMON: assert property (@(posedge pclk) disable iff (!presetn)
    ce && take && !exc_specific |=>
      st_ff.saved[31:16] == {6'h00, $past(st_ff.mstate[25]), 9'h000})
    else $error("common saved status form wrong");

  AST_PRECISE: assert property (@(posedge pclk) disable iff (!presetn)
    ce && exc_req && !exc_older_done |=> !exc_ack && dispatch_hold)
    else $error("exception taken before older instructions completed");

  AST_RESTORE: assert property (@(posedge pclk) disable iff (!presetn)
    ce && ret |=> rfi_ack && st_ff.mstate ==
      ($past(st_ff.saved) & 32'h0205_FFFF))
    else $error("machine state not restored on return");

  AST_LE_COPY: assert property (@(posedge pclk) disable iff (!presetn)
    ce && take |=> st_ff.mstate[0] == $past(st_ff.mstate[16]) &&
      little_endian_mode == $past(st_ff.mstate[16]))
    else $error("byte order not switched on exception");

  AST_RESERVED: assert property (@(posedge pclk) disable iff (!presetn)
    (st_ff.mstate & ~32'h0205_FFFF) == 32'h0000_0000)
    else $error("reserved machine-state bit set");

  AST_POW_MODE: assert property (@(posedge pclk) disable iff (!presetn)
    ce |=> power_mgmt_mode == st_ff.mstate[18])
    else $error("power mode output does not follow machine state");
endmodule

// *** rtl/exu_cfg.svh ***
// offsets, field positions, reset values and masks of the exception unit
`ifndef EXU_CFG_SVH
`define EXU_CFG_SVH

// ***********************************************
// register byte offsets on the apb bus
// ***********************************************
`define EXU_OFS_RESUME    8'h00
`define EXU_OFS_SAVED     8'h04
`define EXU_OFS_MSTATE    8'h08
`define EXU_OFS_IRQ_STS   8'h0C
`define EXU_OFS_IRQ_MSK   8'h10
`define EXU_ADDR_MIN_W    8

// ***********************************************
// machine_state fields, architectural bit n sits at [31-n]
// ***********************************************
`define EXU_MS_VEC        25
`define EXU_MS_POW        18
`define EXU_MS_ILE        16
`define EXU_MS_LE         0
`define EXU_MS_IMPL_MASK  32'h0205_FFFF
`define EXU_MS_RESET      32'h0000_0000

// ***********************************************
// saved status layout: upper half is exception info
// ***********************************************
`define EXU_SV_INFO_HI    31
`define EXU_SV_INFO_LO    16
`define EXU_SV_COPY_HI    15
`define EXU_SV_KEEP_W     16
`define EXU_WORD_RESET    32'h0000_0000

// ***********************************************
// interrupt status bits
// ***********************************************
`define EXU_IRQ_W         3
`define EXU_IRQ_TAKE      0
`define EXU_IRQ_RFI       1
`define EXU_IRQ_VUN       2
`define EXU_IRQ_RESET     3'h0

`endif

// *** rtl/exu_pkg.sv ***
// types shared by the exception unit modules
package exu_pkg;
  `include "exu_cfg.svh"

  typedef logic [31:0]  exu_word_t;  // one register word
  typedef logic [15:0]  exu_info_t;  // exception-specific status

  // whole state of the top module
  typedef struct packed {
    exu_word_t               resume;   // resume address save
    exu_word_t               saved;    // saved status
    exu_word_t               mstate;   // machine state
    logic [`EXU_IRQ_W-1:0]   irq_sts;  // sticky events
    logic [`EXU_IRQ_W-1:0]   irq_msk;  // event enables
    logic                    irq;      // interrupt line
    exu_word_t               prdata;   // apb read data
    logic                    pready;   // apb ready
    logic                    pslverr;  // apb error
    logic                    exc_ack;  // exception taken pulse
    logic                    rfi_ack;  // return done pulse
    logic                    hold;     // dispatch hold
    logic                    vec;      // vector available copy
    logic                    power_mgmt_enable;      // power mode copy
    logic                    le;       // byte order copy
  } exu_state_t;

  // whole state of the vector gate
  typedef struct packed {
    logic grant;    // request may proceed
    logic unavail;  // vector-unavailable raised
  } exu_gate_t;
endpackage

// *** rtl/exu_vec_if.sv ***
// carrier between the exception unit and its vector access gate
`timescale 1ns/100ps
interface exu_vec_if;
  logic vreq_valid;  // vector instruction at dispatch
  logic vreq_stream; // it is a data-streaming instruction
  logic vreq_vsave;  // it touches only the save-mask register
  logic vec_avail;   // vector-available bit of machine state
  logic grant;       // registered grant
  logic unavail;     // registered unavailable pulse

  modport gate (input vreq_valid, vreq_stream, vreq_vsave, vec_avail,
                output grant, unavail);
  modport core (output vreq_valid, vreq_stream, vreq_vsave, vec_avail,
                input grant, unavail);
endinterface

// *** rtl/exu_vec_gate.sv ***
// vector dispatch gate driven by the vector-available bit
`timescale 1ns/100ps
module exu_vec_gate (
  // clock, reset and clock enable
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic ce,
  // request and answer
  exu_vec_if.gate   vif
);
  import exu_pkg::*;

  exu_gate_t st_ff;   // registered answer
  exu_gate_t nxt_st;  // next answer

  // ***********************************************
  // decide grant: streaming and save-mask never gated
  // ***********************************************
  always_comb begin
    nxt_st = '0;
    if (vif.vreq_valid) begin
      if (vif.vreq_stream || vif.vreq_vsave) begin
        nxt_st.grant = 1'b1;
      end else if (vif.vec_avail) begin
        nxt_st.grant = 1'b1;
      end else begin
        nxt_st.unavail = 1'b1;
      end
    end
  end

  // state register, frozen while ce low
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff <= '0;
    end else if (ce) begin
      st_ff <= nxt_st;
    end
  end

  assign vif.grant   = st_ff.grant;
  assign vif.unavail = st_ff.unavail;

  // ***********************************************
  // checks
  // ***********************************************
  AST_VEC_BLOCK: assert property (@(posedge pclk) disable iff (!presetn)
    ce && vif.vreq_valid && !vif.vreq_stream && !vif.vreq_vsave &&
    !vif.vec_avail |=> vif.unavail && !vif.grant)
    else $error("gated vector request was not refused");
  AST_VEC_STREAM: assert property (@(posedge pclk) disable iff (!presetn)
    ce && vif.vreq_valid && vif.vreq_stream |=> vif.grant && !vif.unavail)
    else $error("streaming request was refused");
  AST_VEC_OPEN: assert property (@(posedge pclk) disable iff (!presetn)
    ce && vif.vreq_valid && vif.vec_avail |=> vif.grant)
    else $error("vector request refused while available");
  AST_VEC_VSAVE: assert property (@(posedge pclk) disable iff (!presetn)
    ce && vif.vreq_valid && vif.vreq_vsave |=> vif.grant)
    else $error("save-mask access was refused");
endmodule

// *** bench/exu_disp_model.sv ***
// dispatch and completion side model that feeds the exception unit
`timescale 1ns/100ps
module exu_disp_model (
  // clock
  input  wire logic               pclk,
  // exception request and answer
  output      logic               exc_req,
  output      logic               exc_older_done,
  output      logic               exc_use_next,
  output      logic               exc_specific,
  output      exu_pkg::exu_info_t exc_info,
  output      exu_pkg::exu_word_t exc_pc,
  output      exu_pkg::exu_word_t exc_next_pc,
  input  wire logic               exc_ack,
  input  wire logic               dispatch_hold,
  // return request and answer
  output      logic               rfi_req,
  input  wire logic               rfi_ack
);
  import exu_pkg::*;
  logic hold_seen;  // dispatch hold seen while older work drained
  logic early;      // exception taken before older work finished
  // idle lines at time zero
  initial begin
    exc_req        = 1'b0;
    exc_older_done = 1'b0;
    exc_use_next   = 1'b0;
    exc_specific   = 1'b0;
    exc_info       = 16'h0000;
    exc_pc         = 32'h0000_0000;
    exc_next_pc    = 32'h0000_0000;
    rfi_req        = 1'b0;
  end
  // raise one exception; older work keeps running for lag cycles
  task automatic take(input logic nxt, spc, input exu_info_t info,
                      input exu_word_t pc, npc, input int lag);
    int n;
    n = 0;
    hold_seen = 1'b0;
    early = 1'b0;
    @(posedge pclk);
    exc_req <= 1'b1;
    exc_use_next <= nxt;
    exc_specific <= spc;
    exc_info <= info;
    exc_pc <= pc;
    exc_next_pc <= npc;
    exc_older_done <= (lag == 0);
    repeat (lag) begin
      @(posedge pclk);
      if (dispatch_hold === 1'b1) hold_seen = 1'b1;
      if (exc_ack === 1'b1) early = 1'b1;
    end
    // with no lag the line is already high; never assign it twice
    if (lag != 0) exc_older_done <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (exc_ack !== 1'b1 && n < 20);
    // released request, info and address lines show a changed value, never the last one
    exc_req <= 1'b0;
    exc_older_done <= 1'b0;
    exc_info <= ~info;
    exc_pc <= ~pc;
    exc_next_pc <= ~npc;
  endtask
  // execute one return from exception and wait for the restore
  task automatic ret();
    int n;
    n = 0;
    @(posedge pclk);
    rfi_req <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (rfi_ack !== 1'b1 && n < 20);
    rfi_req <= 1'b0;
  endtask
endmodule

// *** bench/test_exception_state_save_restore.sv ***
// testbench for the exception context save and restore unit
`timescale 1ns/100ps
module test_exception_state_save_restore;
  import exu_pkg::*;
  // ***************************************
  // signals and counters
  // ***************************************
  logic       pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  exu_word_t  pwdata, prdata, resume_addr, exc_pc, exc_next_pc, rd;
  exu_info_t  exc_info;
  logic       exc_req, exc_older_done, exc_use_next, exc_specific;
  logic       exc_ack, dispatch_hold, rfi_req, rfi_ack, bus_err;
  logic       vreq_valid, vreq_stream, vreq_vsave, vreq_grant;
  logic       vreq_unavail, vector_available, power_mgmt_mode;
  logic       little_endian_mode, irq, ce;
  int         n_errors, total_checks, cycles;
  // ***************************************
  // clock, design and partner
  // ***************************************
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  exu_core #(.ADDR_W(8)) i_dut (
    .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .exc_req(exc_req), .exc_older_done(exc_older_done),
    .exc_use_next(exc_use_next), .exc_specific(exc_specific),
    .exc_info(exc_info), .exc_pc(exc_pc), .exc_next_pc(exc_next_pc),
    .exc_ack(exc_ack), .dispatch_hold(dispatch_hold), .rfi_req(rfi_req),
    .rfi_ack(rfi_ack), .resume_addr(resume_addr),
    .vreq_valid(vreq_valid), .vreq_stream(vreq_stream),
    .vreq_vsave(vreq_vsave), .vreq_grant(vreq_grant),
    .vreq_unavail(vreq_unavail), .vector_available(vector_available),
    .power_mgmt_mode(power_mgmt_mode),
    .little_endian_mode(little_endian_mode), .irq(irq));
  exu_disp_model i_disp (
    .pclk(pclk), .exc_req(exc_req), .exc_older_done(exc_older_done),
    .exc_use_next(exc_use_next), .exc_specific(exc_specific),
    .exc_info(exc_info), .exc_pc(exc_pc), .exc_next_pc(exc_next_pc),
    .exc_ack(exc_ack), .dispatch_hold(dispatch_hold),
    .rfi_req(rfi_req), .rfi_ack(rfi_ack));
  // ***************************************
  // shared tasks
  // ***************************************
  // compare and count; four-state so an unknown never matches
  task automatic chk(input exu_word_t got, exp, input string what);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask
  // one apb transfer; request held until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a, input exu_word_t d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    bus_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    chk(pready, 1, "apb ready");
  endtask
  // one vector request; answer is looked at in its single cycle
  task automatic vec_try(input logic st, vs, ok);
    @(posedge pclk);
    vreq_valid <= 1'b1;
    vreq_stream <= st;
    vreq_vsave <= vs;
    @(posedge pclk);
    vreq_valid <= 1'b0;
    #1;
    chk(vreq_grant, ok, "vector grant");
    chk(vreq_unavail, !ok, "vector unavailable");
  endtask
  // let registered mode and interrupt outputs settle
  task automatic settle();
    repeat (2) @(posedge pclk);
    #1;
  endtask
  // ***************************************
  // scenarios
  // ***************************************
  task automatic t_regs();
    for (int a = 0; a <= 16; a += 4) begin
      apb(0, a[7:0], 0);
      chk(rd, 0, "reset value");
    end
    apb(1, 8'h08, 32'hFFFF_FFFF);
    apb(0, 8'h08, 0);
    chk(rd, 32'h0205_FFFF, "reserved bits");
    apb(1, 8'h00, 32'h1234_5678);
    apb(0, 8'h00, 0);
    chk(rd, 32'h1234_5678, "resume rw");
    apb(0, 8'h14, 0);
    chk(bus_err, 1, "unmapped error");
    $display("test regs done");
  endtask
  task automatic t_take_common();
    apb(1, 8'h08, 32'h0205_A5A4);
    i_disp.take(0, 0, 16'hFFFF, 32'h0000_1000, 32'h0000_1004, 2);
    chk(i_disp.hold_seen, 1, "hold while older busy");
    chk(i_disp.early, 0, "taken too early");
    settle();
    chk(resume_addr, 32'h0000_1000, "fault address");
    apb(0, 8'h04, 0);
    chk(rd, 32'h0200_A5A4, "common saved form");
    apb(0, 8'h08, 0);
    chk(rd, 32'h0205_A5A5, "byte order copied");
    chk(little_endian_mode, 1, "byte order out");
    chk(power_mgmt_mode, 1, "power mode out");
    $display("test take_common done");
  endtask
  task automatic t_take_spec();
    i_disp.take(1, 1, 16'h5A3C, 32'h0000_2000, 32'h0000_2004, 0);
    settle();
    chk(resume_addr, 32'h0000_2004, "next address");
    apb(0, 8'h04, 0);
    chk(rd, 32'h5A3C_A5A5, "specific saved form");
    $display("test take_spec done");
  endtask
  task automatic t_rfi();
    apb(1, 8'h04, 32'hFFFF_0F0E);
    i_disp.ret();
    settle();
    apb(0, 8'h08, 0);
    chk(rd, 32'h0205_0F0E, "restored state");
    chk(little_endian_mode, 0, "restored order");
    apb(1, 8'h04, 32'h0000_0000);
    i_disp.ret();
    settle();
    chk(power_mgmt_mode, 0, "normal power");
    chk(vector_available, 0, "vector off");
    $display("test rfi done");
  endtask
  task automatic t_vec();
    vec_try(0, 0, 0);
    vec_try(1, 0, 1);
    vec_try(0, 1, 1);
    apb(1, 8'h08, 32'h0200_0000);
    vec_try(0, 0, 1);
    vec_try(1, 0, 1);
    $display("test vec done");
  endtask
  task automatic t_irq();
    apb(0, 8'h0C, 0);
    chk(rd, 32'h0000_0007, "event status");
    chk(irq, 0, "masked irq");
    apb(1, 8'h10, 32'h0000_0004);
    settle();
    chk(irq, 1, "unmasked irq");
    apb(1, 8'h0C, 32'h0000_0004);
    settle();
    chk(irq, 0, "cleared irq");
    apb(1, 8'h10, 32'h0000_0007);
    settle();
    chk(irq, 1, "other events");
    apb(1, 8'h0C, 32'h0000_0003);
    settle();
    chk(irq, 0, "all cleared");
    $display("test irq done");
  endtask
  // clock enable low must freeze the gate; the request is served later
  task automatic t_ce();
    @(posedge pclk);
    ce <= 1'b0;
    vreq_valid <= 1'b1;
    vreq_stream <= 1'b0;
    vreq_vsave <= 1'b0;
    repeat (3) @(posedge pclk);
    #1;
    chk(vreq_grant, 0, "frozen grant");
    @(posedge pclk);
    ce <= 1'b1;
    @(posedge pclk);
    vreq_valid <= 1'b0;
    #1;
    chk(vreq_grant, 1, "grant after enable");
    $display("test ce done");
  endtask
  // ***************************************
  // run control
  // ***************************************
  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // hang guard, well above the roughly 140 cycles the run needs
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 4000) begin
      n_errors++;
      $display("MISMATCH at %0t: run timed out", $time);
      close_out();
    end
  end
  initial begin
    {presetn, psel, penable, pwrite, vreq_valid} = 5'h00;
    {vreq_stream, vreq_vsave} = 2'h0;
    ce = 1'b1;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_regs();
    t_take_common();
    t_take_spec();
    t_rfi();
    t_vec();
    t_irq();
    t_ce();
    close_out();
  end
endmodule
